// *** cpu_instruction_execution.sv ***
// Execution core for the arithmetic, compare, skip, branch, jump and indirect load instructions.
`timescale 1ns/1ns
module cpu_instruction_execution (
   // Clock and reset.
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // Decoded instruction issue.
   input  wire logic                       issue_valid,
   input  wire cpu_exec_pkg::instr_type    instr,
   output logic                            issue_ready,
   // Selected I/O bit supplied by the I/O fabric on this clock.
   input  wire logic                       io_bit,
   // Data memory port; read data is valid while the read request stands.
   output cpu_exec_pkg::mem_req_type       mem_req,
   input  wire logic [7:0]                 mem_rdata,
   // Architectural state view.
   output logic [15:0]                     pc,
   output logic [7:0]                      flags,
   output logic [15:0]                     sp,
   // Register file read-back.
   input  wire logic [4:0]                 dbg_sel,
   output logic [7:0]                      dbg_data
);

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_EXEC = 4'h1,
      ST_WAIT = 4'h2,
      ST_LOAD = 4'h4,
      ST_PUSH = 4'h8
   } state_type;

   // Register file depth, declared ahead of the array that uses it.
   localparam int REG_COUNT_L = cpu_exec_pkg::REG_COUNT;

   state_type                 state_reg;      // Current sequencer state.
   logic [1:0]                cnt_reg;        // Remaining stall clocks.
   logic [7:0]                rf_reg [REG_COUNT_L];  // General-purpose registers.
   logic [7:0]                flag_reg;       // Status flags.
   logic [15:0]               pc_reg;         // Program counter.
   logic [15:0]               sp_reg;         // Stack pointer.
   logic [7:0]                ret_hi_reg;     // High byte of the pushed return address.
   logic [4:0]                load_dest_reg;  // Destination of a pending load.
   cpu_exec_pkg::mem_req_type mem_reg;        // Registered memory request.
   logic [7:0]                dbg_reg;        // Registered read-back data.

   // Combinational execute results.
   logic                      accept;
   logic [7:0]                rd_val;
   logic [7:0]                rs_val;
   logic [4:0]                dest_hi;
   logic [15:0]               word_val;
   logic [15:0]               word_res;
   logic [15:0]               x_ptr;
   logic [15:0]               z_ptr;
   logic [15:0]               pc_next;
   logic [15:0]               sp_next;
   logic [7:0]                flag_next;
   logic [1:0]                extra;
   logic                      branch_taken;
   logic                      skip_taken;
   logic                      wa_en;
   logic [4:0]                wa_idx;
   logic [7:0]                wa_val;
   logic                      wb_en;
   logic [4:0]                wb_idx;
   logic [7:0]                wb_val;
   cpu_exec_pkg::alu_type     alu;
   cpu_exec_pkg::mem_req_type mem_next;

   // Add two bytes and a carry, returning result with carry, overflow and half carry.
   function automatic cpu_exec_pkg::alu_type add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      cpu_exec_pkg::alu_type r;
      r.res = a + b + {7'h00, ci};
      r.h   = (a[3] & b[3]) | (b[3] & ~r.res[3]) | (~r.res[3] & a[3]);
      r.c   = (a[7] & b[7]) | (b[7] & ~r.res[7]) | (~r.res[7] & a[7]);
      r.v   = (a[7] & b[7] & ~r.res[7]) | (~a[7] & ~b[7] & r.res[7]);
      return r;
   endfunction

   // Subtract a byte and a borrow, returning result with borrow, overflow and half borrow.
   function automatic cpu_exec_pkg::alu_type sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      cpu_exec_pkg::alu_type r;
      r.res = a - b - {7'h00, ci};
      r.h   = (~a[3] & b[3]) | (b[3] & r.res[3]) | (r.res[3] & ~a[3]);
      r.c   = (~a[7] & b[7]) | (b[7] & r.res[7]) | (r.res[7] & ~a[7]);
      r.v   = (a[7] & ~b[7] & ~r.res[7]) | (~a[7] & b[7] & r.res[7]);
      return r;
   endfunction

   // Flags after an 8-bit arithmetic operation; S, T and I are left alone.
   function automatic logic [7:0] arith_flags(input logic [7:0] f, input cpu_exec_pkg::alu_type r, input logic z);
      logic [7:0] n;
      n                      = f;
      n[cpu_exec_pkg::FLAG_C] = r.c;
      n[cpu_exec_pkg::FLAG_Z] = z;
      n[cpu_exec_pkg::FLAG_N] = r.res[7];
      n[cpu_exec_pkg::FLAG_V] = r.v;
      n[cpu_exec_pkg::FLAG_H] = r.h;
      return n;
   endfunction

   // Flags after a logic operation: only zero, negative and a cleared overflow.
   function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] res);
      logic [7:0] n;
      n                      = f;
      n[cpu_exec_pkg::FLAG_Z] = (res == 8'h00);
      n[cpu_exec_pkg::FLAG_N] = res[7];
      n[cpu_exec_pkg::FLAG_V] = 1'h0;
      return n;
   endfunction

   // Relative branch target: the signed offset is added to the next address.
   function automatic logic [15:0] rel_target(input logic [15:0] p, input logic [6:0] off);
      return p + {{9{off[6]}}, off} + cpu_exec_pkg::PC_STEP;
   endfunction

   assign accept      = issue_valid && (state_reg == ST_EXEC);
   assign issue_ready = (state_reg == ST_EXEC);
   assign rd_val      = rf_reg[instr.dest];
   assign rs_val      = rf_reg[instr.src];
   assign dest_hi     = instr.dest + cpu_exec_pkg::PAIR_STEP;
   assign word_val    = {rf_reg[dest_hi], rd_val};
   assign x_ptr       = {rf_reg[cpu_exec_pkg::X_HI_IDX], rf_reg[cpu_exec_pkg::X_LO_IDX]};
   assign z_ptr       = {rf_reg[cpu_exec_pkg::Z_HI_IDX], rf_reg[cpu_exec_pkg::Z_LO_IDX]};

   // Execute decode: an instruction acts in its first clock, except a load's data byte and a call's high push; other later clocks only stall.
   always_comb begin
      alu          = '0;
      word_res     = '0;
      flag_next    = flag_reg;
      pc_next      = pc_reg + cpu_exec_pkg::PC_STEP;
      sp_next      = sp_reg;
      extra        = cpu_exec_pkg::EXTRA_NONE;
      branch_taken = 1'h0;
      skip_taken   = 1'h0;
      wa_en        = 1'h0;
      wa_idx       = instr.dest;
      wa_val       = 8'h00;
      wb_en        = 1'h0;
      wb_idx       = dest_hi;
      wb_val       = 8'h00;
      mem_next     = '0;
      case (instr.op)
         cpu_exec_pkg::OP_ADD_CARRY: begin
            alu       = add8(rd_val, rs_val, flag_reg[cpu_exec_pkg::FLAG_C]);
            wa_en     = 1'h1;
            wa_val    = alu.res;
            flag_next = arith_flags(flag_reg, alu, alu.res == 8'h00);
         end
         cpu_exec_pkg::OP_WORD_SUM, cpu_exec_pkg::OP_WORD_DIFF: begin
            // The immediate is six bits wide, zero extended onto the pair.
            if (instr.op == cpu_exec_pkg::OP_WORD_SUM) begin
               word_res                       = word_val + {10'h000, instr.imm[5:0]};
               flag_next[cpu_exec_pkg::FLAG_V] = ~word_val[15] & word_res[15];
               flag_next[cpu_exec_pkg::FLAG_C] = ~word_res[15] & word_val[15];
            end else begin
               word_res                       = word_val - {10'h000, instr.imm[5:0]};
               flag_next[cpu_exec_pkg::FLAG_V] = word_val[15] & ~word_res[15];
               flag_next[cpu_exec_pkg::FLAG_C] = word_res[15] & ~word_val[15];
            end
            flag_next[cpu_exec_pkg::FLAG_Z] = (word_res == 16'h0000);
            flag_next[cpu_exec_pkg::FLAG_N] = word_res[15];
            flag_next[cpu_exec_pkg::FLAG_S] = word_res[15] ^ flag_next[cpu_exec_pkg::FLAG_V];
            wa_en  = 1'h1;
            wa_val = word_res[7:0];
            wb_en  = 1'h1;
            wb_val = word_res[15:8];
            extra  = cpu_exec_pkg::EXTRA_ONE;
         end
         cpu_exec_pkg::OP_SUB_CARRY, cpu_exec_pkg::OP_CONST_CARRY_DIFF: begin
            // Zero only survives a chained subtract, so multi-byte results test zero as a whole.
            alu = sub8(rd_val, (instr.op == cpu_exec_pkg::OP_SUB_CARRY) ? rs_val : instr.imm,
                       flag_reg[cpu_exec_pkg::FLAG_C]);
            wa_en     = 1'h1;
            wa_val    = alu.res;
            flag_next = arith_flags(flag_reg, alu, (alu.res == 8'h00) & flag_reg[cpu_exec_pkg::FLAG_Z]);
         end
         cpu_exec_pkg::OP_CONST_DIFF, cpu_exec_pkg::OP_IMM_COMPARE: begin
            alu       = sub8(rd_val, instr.imm, 1'h0);
            wa_en     = (instr.op == cpu_exec_pkg::OP_CONST_DIFF);
            wa_val    = alu.res;
            flag_next = arith_flags(flag_reg, alu, alu.res == 8'h00);
         end
         cpu_exec_pkg::OP_CONST_MASK, cpu_exec_pkg::OP_ZERO_SIGN: begin
            // Testing a register is a mask with itself, so the stored value is unchanged.
            wa_val    = rd_val & ((instr.op == cpu_exec_pkg::OP_ZERO_SIGN) ? rd_val :
                                  instr.imm);
            wa_en     = 1'h1;
            flag_next = logic_flags(flag_reg, wa_val);
         end
         cpu_exec_pkg::OP_CONST_MERGE, cpu_exec_pkg::OP_BIT_SET: begin
            wa_val    = rd_val | instr.imm;
            wa_en     = 1'h1;
            flag_next = logic_flags(flag_reg, wa_val);
         end
         cpu_exec_pkg::OP_PTR_JUMP: begin
            pc_next = z_ptr;
            extra   = cpu_exec_pkg::EXTRA_ONE;
         end
         cpu_exec_pkg::OP_PTR_CALL: begin
            // Low return byte goes first; the high byte follows in the push state.
            mem_next.wr    = 1'h1;
            mem_next.addr  = sp_reg;
            mem_next.wdata = pc_reg[7:0] + cpu_exec_pkg::PC_STEP[7:0];
            sp_next        = sp_reg - cpu_exec_pkg::PTR_STEP;
            pc_next        = z_ptr;
         end
         cpu_exec_pkg::OP_EQUAL_SKIP, cpu_exec_pkg::OP_REG_BIT_CLEAR_SKIP,
         cpu_exec_pkg::OP_IO_BIT_SET_SKIP: begin
            case (instr.op)
               cpu_exec_pkg::OP_EQUAL_SKIP:         skip_taken = (rd_val == rs_val);
               cpu_exec_pkg::OP_REG_BIT_CLEAR_SKIP: skip_taken = ~rs_val[instr.bit_sel];
               default:               skip_taken = io_bit;
            endcase
            if (skip_taken) begin
               pc_next = pc_reg + (instr.next_two_word ? cpu_exec_pkg::SKIP_TWO : cpu_exec_pkg::SKIP_ONE);
               extra   = instr.next_two_word ? cpu_exec_pkg::EXTRA_TWO : cpu_exec_pkg::EXTRA_ONE;
            end
         end
         cpu_exec_pkg::OP_FLAG_SET_BRANCH, cpu_exec_pkg::OP_SIGNED_GE_BRANCH,
         cpu_exec_pkg::OP_SIGNED_LT_BRANCH, cpu_exec_pkg::OP_IRQ_ON_BRANCH: begin
            case (instr.op)
               cpu_exec_pkg::OP_FLAG_SET_BRANCH:  branch_taken = flag_reg[instr.bit_sel];
               cpu_exec_pkg::OP_SIGNED_GE_BRANCH: branch_taken = ~(flag_reg[cpu_exec_pkg::FLAG_N] ^
                                                     flag_reg[cpu_exec_pkg::FLAG_V]);
               cpu_exec_pkg::OP_SIGNED_LT_BRANCH: branch_taken = flag_reg[cpu_exec_pkg::FLAG_N] ^
                                                   flag_reg[cpu_exec_pkg::FLAG_V];
               default:             branch_taken = flag_reg[cpu_exec_pkg::FLAG_I];
            endcase
            if (branch_taken) begin
               pc_next = rel_target(pc_reg, instr.offset);
               extra   = cpu_exec_pkg::EXTRA_ONE;
            end
         end
         cpu_exec_pkg::OP_LOAD_POST_INC, cpu_exec_pkg::OP_LOAD_PRE_DEC: begin
            // The pointer is rewritten now; the loaded byte lands in the second clock.
            mem_next.rd   = 1'h1;
            mem_next.addr = (instr.op == cpu_exec_pkg::OP_LOAD_POST_INC) ? x_ptr :
                            x_ptr - cpu_exec_pkg::PTR_STEP;
            word_res      = (instr.op == cpu_exec_pkg::OP_LOAD_POST_INC) ? x_ptr + cpu_exec_pkg::PTR_STEP :
                                                             x_ptr - cpu_exec_pkg::PTR_STEP;
            wa_en  = 1'h1;
            wa_idx = cpu_exec_pkg::X_LO_IDX;
            wa_val = word_res[7:0];
            wb_en  = 1'h1;
            wb_idx = cpu_exec_pkg::X_HI_IDX;
            wb_val = word_res[15:8];
         end
         default: begin
            pc_next = pc_reg + cpu_exec_pkg::PC_STEP;
         end
      endcase
   end

   // Sequencer: holds off the next issue for the extra clocks of long instructions.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_EXEC;
         cnt_reg   <= cpu_exec_pkg::EXTRA_NONE;
      end else begin
         case (state_reg)
            ST_EXEC: begin
               if (accept && (instr.op == cpu_exec_pkg::OP_PTR_CALL)) begin
                  state_reg <= ST_PUSH;
               end else if (accept && ((instr.op == cpu_exec_pkg::OP_LOAD_POST_INC) ||
                                       (instr.op == cpu_exec_pkg::OP_LOAD_PRE_DEC))) begin
                  state_reg <= ST_LOAD;
               end else if (accept && (extra != cpu_exec_pkg::EXTRA_NONE)) begin
                  state_reg <= ST_WAIT;
                  cnt_reg   <= extra;
               end
            end
            ST_WAIT: begin
               cnt_reg <= cnt_reg - cpu_exec_pkg::EXTRA_ONE;
               if (cnt_reg == cpu_exec_pkg::EXTRA_ONE) begin
                  state_reg <= ST_EXEC;
               end
            end
            ST_PUSH: begin
               // The third clock of a call carries the second push on the memory port while issue stays held off.
               state_reg <= ST_WAIT;
               cnt_reg   <= cpu_exec_pkg::EXTRA_ONE;
            end
            ST_LOAD: begin
               state_reg <= ST_EXEC;
            end
            default: begin
               state_reg <= ST_EXEC;
            end
         endcase
      end
   end

   // Memory request register: a request stands for exactly one clock.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_reg <= '0;
      end else if (accept) begin
         mem_reg <= mem_next;
      end else if (state_reg == ST_PUSH) begin
         mem_reg.rd    <= 1'h0;
         mem_reg.wr    <= 1'h1;
         mem_reg.addr  <= sp_reg;
         mem_reg.wdata <= ret_hi_reg;
      end else begin
         mem_reg <= '0;
      end
   end

   // Program counter, stack pointer, flags and call bookkeeping.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pc_reg        <= cpu_exec_pkg::PC_RESET;
         sp_reg        <= cpu_exec_pkg::SP_RESET;
         flag_reg      <= cpu_exec_pkg::FLAGS_RESET;
         ret_hi_reg    <= 8'h00;
         load_dest_reg <= 5'h00;
      end else if (accept) begin
         pc_reg        <= pc_next;
         sp_reg        <= sp_next;
         flag_reg      <= flag_next;
         ret_hi_reg    <= pc_reg[15:8] + {7'h00, &pc_reg[7:0]};
         load_dest_reg <= instr.dest;
      end else if (state_reg == ST_PUSH) begin
         sp_reg <= sp_reg - cpu_exec_pkg::PTR_STEP;
      end
   end

   // Register file; the load result arrives in the clock after its request.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < REG_COUNT_L; i++) begin
            rf_reg[i] <= 8'h00;
         end
      end else begin
         if (accept && wa_en) begin
            rf_reg[wa_idx] <= wa_val;
         end
         if (accept && wb_en) begin
            rf_reg[wb_idx] <= wb_val;
         end
         if (state_reg == ST_LOAD) begin
            rf_reg[load_dest_reg] <= mem_rdata;
         end
      end
   end

   // Read-back port, registered so that the data output comes from a flip-flop.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dbg_reg <= 8'h00;
      end else begin
         dbg_reg <= rf_reg[dbg_sel];
      end
   end

   assign mem_req  = mem_reg;
   assign pc       = pc_reg;
   assign flags    = flag_reg;
   assign sp       = sp_reg;
   assign dbg_data = dbg_reg;

   // Checks on timing and effects, kept next to the logic.
   word_sum_two_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_WORD_SUM |=> !issue_ready ##1 issue_ready)
      else $error("word add not two clocks");
   word_diff_two_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_WORD_DIFF |=> !issue_ready ##1 issue_ready)
      else $error("word sub not two clocks");
   jump_pc_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_PTR_JUMP |=> pc_reg == $past(z_ptr) && flag_reg == $past(flag_reg))
      else $error("pointer jump target or flags wrong");
   call_three_clk_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_PTR_CALL |=> mem_reg.wr ##1 mem_reg.wr ##1 issue_ready)
      else $error("pointer call not three clocks with two pushes");
   skip_flags_kept_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_EQUAL_SKIP |=> flag_reg == $past(flag_reg))
      else $error("equal skip altered flags");
   mask_clears_v_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_CONST_MASK |=> !flag_reg[cpu_exec_pkg::FLAG_V] &&
      flag_reg[cpu_exec_pkg::FLAG_C] == $past(flag_reg[cpu_exec_pkg::FLAG_C])) else $error("mask flags wrong");
   branch_untaken_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && !branch_taken && instr.op == cpu_exec_pkg::OP_SIGNED_LT_BRANCH |=> issue_ready &&
      pc_reg == $past(pc_reg) + cpu_exec_pkg::PC_STEP) else $error("untaken branch not one clock");
   skip_two_word_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && skip_taken && instr.next_two_word |=> !issue_ready [*2] ##1 issue_ready)
      else $error("two word skip not three clocks");
   load_two_clk_a: assert property (@(posedge sys_clk) disable iff (rst)
      accept && instr.op == cpu_exec_pkg::OP_LOAD_POST_INC |=> mem_reg.rd &&
      mem_reg.addr == $past(x_ptr) ##1 issue_ready)
      else $error("post increment load wrong");

endmodule // cpu_instruction_execution

// *** cpu_exec_pkg.sv ***
// Shared constants, operation codes and carrier types for the instruction execution core.
package cpu_exec_pkg;

   // Register file geometry and pointer pair locations.
   localparam int        REG_COUNT = 32;
   localparam logic [4:0] X_LO_IDX = 5'h1A;
   localparam logic [4:0] X_HI_IDX = 5'h1B;
   localparam logic [4:0] Z_LO_IDX = 5'h1E;
   localparam logic [4:0] Z_HI_IDX = 5'h1F;
   localparam logic [4:0] PAIR_STEP = 5'h01;

   // Bit positions inside the flag register.
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // Reset values of the architectural state.
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [15:0] SP_RESET    = 16'h00FF;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;

   // Program counter steps and pointer step.
   localparam logic [15:0] PC_STEP   = 16'h0001;
   localparam logic [15:0] SKIP_ONE  = 16'h0002;
   localparam logic [15:0] SKIP_TWO  = 16'h0003;
   localparam logic [15:0] PTR_STEP  = 16'h0001;

   // Extra stall clocks beyond the first execute clock.
   localparam logic [1:0] EXTRA_NONE = 2'h0;
   localparam logic [1:0] EXTRA_ONE  = 2'h1;
   localparam logic [1:0] EXTRA_TWO  = 2'h2;

   // Decoded operations handled by this core.
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD_CARRY, OP_WORD_SUM, OP_WORD_DIFF, OP_SUB_CARRY, OP_CONST_DIFF,
      OP_CONST_CARRY_DIFF, OP_CONST_MASK, OP_CONST_MERGE, OP_ZERO_SIGN, OP_BIT_SET,
      OP_PTR_JUMP, OP_PTR_CALL, OP_EQUAL_SKIP, OP_IMM_COMPARE, OP_REG_BIT_CLEAR_SKIP,
      OP_IO_BIT_SET_SKIP, OP_FLAG_SET_BRANCH, OP_SIGNED_GE_BRANCH, OP_SIGNED_LT_BRANCH,
      OP_IRQ_ON_BRANCH, OP_LOAD_POST_INC, OP_LOAD_PRE_DEC
   } op_type;

   // One decoded instruction as presented by the fetch stage.
   typedef struct packed {
      op_type     op;
      logic [4:0] dest;
      logic [4:0] src;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [6:0] offset;
      logic       next_two_word;
   } instr_type;

   // Data memory request toward the memory fabric.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_req_type;

   // Result of an 8-bit add or subtract.
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       v;
      logic       h;
   } alu_type;

endpackage

// *** tb_top.sv ***
// Self-checking testbench for the instruction execution core.
`timescale 1ns/1ns
module tb_top;
   // Stimulus and observed ports of the core.
   logic                      sys_clk = 1'b0;
   logic                      rst = 1'b1;
   logic                      issue_valid = 1'b0;
   cpu_exec_pkg::instr_type   instr = '0;
   logic                      issue_ready;
   logic                      io_bit = 1'b0;
   cpu_exec_pkg::mem_req_type mem_req;
   logic [7:0]                mem_rdata;
   logic [15:0]               pc;
   logic [15:0]               sp;
   logic [7:0]                flags;
   logic [4:0]                dbg_sel = 5'h00;
   logic [7:0]                dbg_data;
   logic [7:0]                wlog [0:255];  // Bytes the core wrote, by low address.
   int                        n_errors = 0;
   int                        total_checks = 0;
   int                        cycles = 0;
   logic [15:0]               p;
   logic [15:0]               s;

   // Memory answers reads with a pattern of the address; outside a read it shows a changing value.
   assign mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ 8'h3C) : ~mem_req.addr[7:0];
   always #10 sys_clk = ~sys_clk;

   // Logs data writes and cuts a hang short.
   always @(posedge sys_clk) begin
      cycles++;
      if (mem_req.wr) wlog[mem_req.addr[7:0]] <= mem_req.wdata;
      if (cycles > 3000) begin
         n_errors++;
         results();
      end
   end

   cpu_instruction_execution dut (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
      .issue_ready(issue_ready), .io_bit(io_bit), .mem_req(mem_req), .mem_rdata(mem_rdata), .pc(pc),
      .flags(flags), .sp(sp), .dbg_sel(dbg_sel), .dbg_data(dbg_data));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Issues one instruction and checks the clocks until ready; k also gives bit, offset and skip length.
   task ex(input cpu_exec_pkg::op_type op, input logic [4:0] d, input logic [7:0] k, input int cyc);
      int n;
      @(negedge sys_clk);
      instr = '{op, d, d, k, k[2:0], k[6:0], k[7]};
      issue_valid = 1'b1;
      @(negedge sys_clk);
      issue_valid = 1'b0;
      n = 1;
      while (issue_ready !== 1'b1 && n < 8) begin
         @(negedge sys_clk);
         n++;
      end
      chk(16'(n), 16'(cyc));
   endtask

   // Reads a register back; the value arrives one clock after the select.
   task rdchk(input logic [4:0] r, input logic [7:0] exp);
      @(negedge sys_clk);
      dbg_sel = r;
      @(negedge sys_clk);
      chk({8'h00, dbg_data}, {8'h00, exp});
   endtask

   task results;
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Byte arithmetic and logic with exact flag images.
   task t_logic;
      ex(cpu_exec_pkg::OP_CONST_MERGE, 5'h10, 8'h5A, 1); rdchk(5'h10, 8'h5A);
      ex(cpu_exec_pkg::OP_CONST_MASK, 5'h10, 8'h0F, 1); rdchk(5'h10, 8'h0A);
      ex(cpu_exec_pkg::OP_ZERO_SIGN, 5'h10, 8'h00, 1); rdchk(5'h10, 8'h0A);
      ex(cpu_exec_pkg::OP_CONST_DIFF, 5'h10, 8'h0A, 1); chk(flags, 16'h0002);
      ex(cpu_exec_pkg::OP_CONST_CARRY_DIFF, 5'h10, 8'h01, 1); chk(flags, 16'h0025);
      ex(cpu_exec_pkg::OP_SUB_CARRY, 5'h10, 8'h00, 1); rdchk(5'h10, 8'hFF);
      ex(cpu_exec_pkg::OP_ADD_CARRY, 5'h10, 8'h00, 1); rdchk(5'h10, 8'hFF);
      ex(cpu_exec_pkg::OP_IMM_COMPARE, 5'h10, 8'hFF, 1); chk(flags, 16'h0002);
      ex(cpu_exec_pkg::OP_BIT_SET, 5'h11, 8'h81, 1); chk(flags, 16'h0004);
   endtask

   // Taken and untaken branches; N is set and V clear here.
   task t_branch;
      p = pc;
      ex(cpu_exec_pkg::OP_FLAG_SET_BRANCH, 5'h00, 8'h0A, 2); chk(pc, p + 16'h000B);
      ex(cpu_exec_pkg::OP_SIGNED_LT_BRANCH, 5'h00, 8'h7E, 2); chk(pc, p + 16'h000A);
      ex(cpu_exec_pkg::OP_SIGNED_GE_BRANCH, 5'h00, 8'h10, 1); chk(pc, p + 16'h000B);
      ex(cpu_exec_pkg::OP_IRQ_ON_BRANCH, 5'h00, 8'h10, 1); chk(pc, p + 16'h000C);
      ex(cpu_exec_pkg::OP_FLAG_SET_BRANCH, 5'h00, 8'h08, 1); chk(pc, p + 16'h000D);
      ex(cpu_exec_pkg::OP_WORD_SUM, 5'h18, 8'h01, 2); rdchk(5'h18, 8'h01);
      ex(cpu_exec_pkg::OP_WORD_DIFF, 5'h18, 8'h02, 2); rdchk(5'h19, 8'hFF);
      chk(flags, 16'h0015);
   endtask

   // Indirect loads, skips and pointer transfers.
   task t_rest;
      ex(cpu_exec_pkg::OP_CONST_MERGE, 5'h1A, 8'h10, 1);
      ex(cpu_exec_pkg::OP_LOAD_POST_INC, 5'h02, 8'h00, 2); rdchk(5'h02, 8'h2C); rdchk(5'h1A, 8'h11);
      ex(cpu_exec_pkg::OP_LOAD_PRE_DEC, 5'h03, 8'h00, 2); rdchk(5'h03, 8'h2C); rdchk(5'h1A, 8'h10);
      p = pc;
      ex(cpu_exec_pkg::OP_EQUAL_SKIP, 5'h10, 8'h80, 3); chk(pc, p + 16'h0003);
      ex(cpu_exec_pkg::OP_REG_BIT_CLEAR_SKIP, 5'h00, 8'h00, 2); chk(pc, p + 16'h0005);
      io_bit = 1'b1;
      ex(cpu_exec_pkg::OP_IO_BIT_SET_SKIP, 5'h00, 8'h00, 2); chk(pc, p + 16'h0007);
      io_bit = 1'b0;
      ex(cpu_exec_pkg::OP_IO_BIT_SET_SKIP, 5'h00, 8'h00, 1); chk(pc, p + 16'h0008);
      ex(cpu_exec_pkg::OP_CONST_MERGE, 5'h1E, 8'h40, 1);
      p = pc + 16'h0001;
      s = sp;
      ex(cpu_exec_pkg::OP_PTR_CALL, 5'h00, 8'h00, 3); chk(pc, 16'h0040); chk(sp, s - 16'h0002);
      chk({8'h00, wlog[s[7:0]]}, {8'h00, p[7:0]});
      chk({8'h00, wlog[s[7:0] - 8'h01]}, {8'h00, p[15:8]});
      ex(cpu_exec_pkg::OP_CONST_MERGE, 5'h1E, 8'h02, 1);
      ex(cpu_exec_pkg::OP_PTR_JUMP, 5'h00, 8'h00, 2); chk(pc, 16'h0042);
   endtask

   // Reset for five clocks, then the scenarios in an order that builds the flag state each one needs.
   initial begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      t_logic();
      t_branch();
      t_rest();
      results();
   end
endmodule // tb_top
